/* File: bidir_fifo.v */
// Purpose: two-port bidirectional fifo with flags, mailboxes and parity checking
// Assumes: port clocks and all pins are synchronous to sys_clk and sampled by it
// Notes:   each port acts on a sampled rising edge of its own port clock
//
// Functional notes
// - port b acts only while select low
// - port b data floats while select high
// - port a empty flag blocks b-to-a reads
// - port a empty rises second edge after write
// - port b empty flag blocks a-to-b reads
// - port b empty rises second edge after write
// - port a acts only while enable high
// - port b acts only while enable high
// - port a full flag blocks a-to-b writes
// - port a full rises second edge after reset
// - port b full flag blocks b-to-a writes
// - port b full rises second edge after reset
// - offset selects latched when reset releases
// - port a mailbox select picks mailbox data
// - a-to-b mailbox write clears flag, locks mailbox
// - a-to-b flag set by port b mailbox read
// - b-to-a mailbox write clears flag, locks mailbox
// - b-to-a flag set by port a mailbox read
// - parity type input selects odd or even
// - port a error flag on any bad byte
// - port a error forced high on generating mailbox read
// - port b error checks only valid bytes
// - reset sets mail and parity error flags high, empty and full flags low
// - write/read select high writes, floats outputs
// - both size bits high select mailboxes
// - parity generation fills byte top bits
//
// The address map and the Avalon-MM register port were left to the implementer.
`include "bidir_fifo_defines.vh"
`timescale 1ns/100ps
`default_nettype none

module bidir_fifo (
  // system
  input  wire                  sys_clk,
  input  wire                  nrst,
  // shared straps
  input  wire                  offset_select_lo,
  input  wire                  offset_select_hi,
  input  wire                  parity_odd,
  // port a control
  input  wire                  port_a_clock,
  input  wire                  port_a_select_n,
  input  wire                  port_a_enable,
  input  wire                  port_a_write_read,
  input  wire                  port_a_mailbox_select,
  input  wire                  port_a_parity_gen_en,
  // port a data pin
  input  wire [`WORD_W-1:0]    port_a_data_in,
  output reg  [`WORD_W-1:0]    port_a_data_out,
  output reg                   port_a_data_oe_n,
  // port a flags
  output reg                   port_a_empty_n,
  output reg                   port_a_full_n,
  output reg                   port_a_parity_error_n,
  // port b control
  input  wire                  port_b_clock,
  input  wire                  port_b_select_n,
  input  wire                  port_b_enable,
  input  wire                  port_b_write_read,
  input  wire                  port_b_size_lo,
  input  wire                  port_b_size_hi,
  input  wire                  port_b_parity_gen_en,
  // port b data pin
  input  wire [`WORD_W-1:0]    port_b_data_in,
  output reg  [`WORD_W-1:0]    port_b_data_out,
  output reg                   port_b_data_oe_n,
  // port b flags
  output reg                   port_b_empty_n,
  output reg                   port_b_full_n,
  output reg                   port_b_parity_error_n,
  // mailbox flags
  output reg                   a_to_b_mail_flag_n,
  output reg                   b_to_a_mail_flag_n,
  // avalon-mm slave
  input  wire [3:0]            avs_address,
  input  wire                  avs_read,
  input  wire                  avs_write,
  input  wire [31:0]           avs_writedata,
  output reg  [31:0]           avs_readdata,
  output reg                   avs_waitrequest
);

  // parity of a nine-bit byte is good when its ones count matches the type
  function byte_bad;
    input [`BYTE_W-1:0] b;
    input               odd;
    begin
      byte_bad = (^b) != odd;
    end
  endfunction

  // per-byte check over a whole word, masked by the valid bytes
  function word_bad;
    input [`WORD_W-1:0] w;
    input [3:0]         valid;
    input               odd;
    integer             i;
    begin
      word_bad = 1'b0;
      for (i = 0; i < 4; i = i + 1) begin
        if (valid[i] && byte_bad(w[i*`BYTE_W +: `BYTE_W], odd))
          word_bad = 1'b1;
      end
    end
  endfunction

  // replace the top bit of each byte with generated parity
  function [`WORD_W-1:0] gen_word;
    input [`WORD_W-1:0] w;
    input               en;
    input               odd;
    integer             i;
    begin
      gen_word = w;
      for (i = 0; i < 4; i = i + 1) begin
        if (en)
          gen_word[i*`BYTE_W+8] = (^w[i*`BYTE_W +: 8]) ^ odd;
      end
    end
  endfunction

  // storage, one array per direction
  reg  [`WORD_W-1:0]  a2b_mem [0:`DEPTH-1];
  reg  [`WORD_W-1:0]  b2a_mem [0:`DEPTH-1];

  reg                 clk_a_prev_reg;
  reg                 clk_b_prev_reg;
  reg  [`PTR_W-1:0]   a2b_wr_reg;
  reg  [`PTR_W-1:0]   a2b_rd_reg;
  reg  [`PTR_W-1:0]   b2a_wr_reg;
  reg  [`PTR_W-1:0]   b2a_rd_reg;
  reg  [`WORD_W-1:0]  a2b_out_reg;
  reg  [`WORD_W-1:0]  b2a_out_reg;
  reg  [`WORD_W-1:0]  a2b_mail_reg;
  reg  [`WORD_W-1:0]  b2a_mail_reg;
  reg                 a_empty_stage_reg;
  reg                 b_empty_stage_reg;
  reg                 a_full_stage_reg;
  reg                 b_full_stage_reg;
  reg                 offset_taken_reg;
  reg  [1:0]          offset_sel_reg;
  reg                 ctrl_chk_en_reg;

  wire [`PTR_W-1:0]   a2b_wr_next;
  wire [`PTR_W-1:0]   a2b_rd_next;
  wire [`PTR_W-1:0]   b2a_wr_next;
  wire [`PTR_W-1:0]   b2a_rd_next;
  wire [`PTR_W-1:0]   a2b_level;
  wire [`PTR_W-1:0]   b2a_level;
  wire [`PTR_W-1:0]   a2b_level_next;
  wire [`PTR_W-1:0]   b2a_level_next;
  reg  [`PTR_W-1:0]   offset_val;
  reg  [3:0]          b_valid;

  // port edges: pins are synchronous, so a one-flop history is enough
  wire edge_a = port_a_clock & ~clk_a_prev_reg;
  wire edge_b = port_b_clock & ~clk_b_prev_reg;

  // qualified accesses
  wire acc_a   = edge_a & ~port_a_select_n & port_a_enable;
  wire acc_b   = edge_b & ~port_b_select_n & port_b_enable;
  wire mail_b  = port_b_size_hi & port_b_size_lo;
  wire a_write = acc_a & port_a_write_read;
  wire a_read  = acc_a & ~port_a_write_read;
  wire b_write = acc_b & port_b_write_read;
  wire b_read  = acc_b & ~port_b_write_read;

  // fifo pushes and pops gated by the flag registers, not raw levels
  wire a2b_push  = a_write & ~port_a_mailbox_select & port_a_full_n;
  wire a2b_pop   = b_read & ~mail_b & port_b_empty_n;
  wire b2a_push  = b_write & ~mail_b & port_b_full_n;
  wire b2a_pop   = a_read & ~port_a_mailbox_select & port_a_empty_n;
  wire a2b_mwr   = a_write & port_a_mailbox_select & a_to_b_mail_flag_n;
  wire b2a_mwr   = b_write & mail_b & b_to_a_mail_flag_n;
  wire a2b_mrd   = b_read & mail_b;
  wire b2a_mrd   = a_read & port_a_mailbox_select;

  assign a2b_wr_next    = a2b_wr_reg + {{(`PTR_W-1){1'b0}}, a2b_push};
  assign a2b_rd_next    = a2b_rd_reg + {{(`PTR_W-1){1'b0}}, a2b_pop};
  assign b2a_wr_next    = b2a_wr_reg + {{(`PTR_W-1){1'b0}}, b2a_push};
  assign b2a_rd_next    = b2a_rd_reg + {{(`PTR_W-1){1'b0}}, b2a_pop};
  assign a2b_level      = a2b_wr_reg - a2b_rd_reg;
  assign b2a_level      = b2a_wr_reg - b2a_rd_reg;
  assign a2b_level_next = a2b_wr_next - a2b_rd_next;
  assign b2a_level_next = b2a_wr_next - b2a_rd_next;

  // offset preset table and port b byte-valid mask
  always @* begin
    case (offset_sel_reg)
      2'h0:    offset_val = `OFFSET_0;
      2'h1:    offset_val = `OFFSET_1;
      2'h2:    offset_val = `OFFSET_2;
      default: offset_val = `OFFSET_3;
    endcase
    case ({port_b_size_hi, port_b_size_lo})
      `SIZE_WORD: b_valid = `MASK_WORD;
      `SIZE_BYTE: b_valid = `MASK_BYTE;
      default:    b_valid = `MASK_LONG;
    endcase
  end

  // memory writes carry no reset, which keeps them plain ram
  always @(posedge sys_clk) begin
    if (a2b_push)
      a2b_mem[a2b_wr_reg[`ADDR_W-1:0]] <= port_a_data_in;
    if (b2a_push)
      b2a_mem[b2a_wr_reg[`ADDR_W-1:0]] <= port_b_data_in;
  end

  // pointers, output registers and mailboxes
  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      clk_a_prev_reg <= 1'b0;
      clk_b_prev_reg <= 1'b0;
      a2b_wr_reg     <= {`PTR_W{1'b0}};
      a2b_rd_reg     <= {`PTR_W{1'b0}};
      b2a_wr_reg     <= {`PTR_W{1'b0}};
      b2a_rd_reg     <= {`PTR_W{1'b0}};
      a2b_out_reg    <= {`WORD_W{1'b0}};
      b2a_out_reg    <= {`WORD_W{1'b0}};
      a2b_mail_reg   <= {`WORD_W{1'b0}};
      b2a_mail_reg   <= {`WORD_W{1'b0}};
    end else begin
      clk_a_prev_reg <= port_a_clock;
      clk_b_prev_reg <= port_b_clock;
      a2b_wr_reg     <= a2b_wr_next;
      a2b_rd_reg     <= a2b_rd_next;
      b2a_wr_reg     <= b2a_wr_next;
      b2a_rd_reg     <= b2a_rd_next;
      if (a2b_pop)
        a2b_out_reg <= a2b_mem[a2b_rd_reg[`ADDR_W-1:0]];
      if (b2a_pop)
        b2a_out_reg <= b2a_mem[b2a_rd_reg[`ADDR_W-1:0]];
      if (a2b_mwr)
        a2b_mail_reg <= port_a_data_in;
      if (b2a_mwr)
        b2a_mail_reg <= port_b_data_in;
    end
  end

  // empty/full flags: two edges of the flag's own port to rise, immediate fall
  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      a_empty_stage_reg <= 1'b0;
      b_empty_stage_reg <= 1'b0;
      a_full_stage_reg  <= 1'b0;
      b_full_stage_reg  <= 1'b0;
      port_a_empty_n    <= 1'b0;
      port_b_empty_n    <= 1'b0;
      port_a_full_n     <= 1'b0;
      port_b_full_n     <= 1'b0;
    end else begin
      if (edge_a) begin
        a_empty_stage_reg <= b2a_level_next != {`PTR_W{1'b0}};
        port_a_empty_n    <= a_empty_stage_reg & (b2a_level_next != {`PTR_W{1'b0}});
        a_full_stage_reg  <= a2b_level_next != `DEPTH;
        port_a_full_n     <= a_full_stage_reg & (a2b_level_next != `DEPTH);
      end
      if (edge_b) begin
        b_empty_stage_reg <= a2b_level_next != {`PTR_W{1'b0}};
        port_b_empty_n    <= b_empty_stage_reg & (a2b_level_next != {`PTR_W{1'b0}});
        b_full_stage_reg  <= b2a_level_next != `DEPTH;
        port_b_full_n     <= b_full_stage_reg & (b2a_level_next != `DEPTH);
      end
    end
  end

  // mail flags: a write (new mail) wins over a same-cycle read
  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      a_to_b_mail_flag_n <= 1'b1;
      b_to_a_mail_flag_n <= 1'b1;
    end else begin
      if (a2b_mwr)
        a_to_b_mail_flag_n <= 1'b0;
      else if (a2b_mrd)
        a_to_b_mail_flag_n <= 1'b1;
      if (b2a_mwr)
        b_to_a_mail_flag_n <= 1'b0;
      else if (b2a_mrd)
        b_to_a_mail_flag_n <= 1'b1;
    end
  end

  // offset straps caught on the first clock after reset release
  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      offset_taken_reg <= 1'b0;
      offset_sel_reg   <= 2'h0;
    end else if (!offset_taken_reg) begin
      offset_taken_reg <= 1'b1;
      offset_sel_reg   <= {offset_select_hi, offset_select_lo};
    end
  end

  // data pins and parity flags; check is passive and may be masked by software
  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      port_a_data_out       <= {`WORD_W{1'b0}};
      port_b_data_out       <= {`WORD_W{1'b0}};
      port_a_data_oe_n      <= 1'b1;
      port_b_data_oe_n      <= 1'b1;
      port_a_parity_error_n <= 1'b1;
      port_b_parity_error_n <= 1'b1;
    end else begin
      port_a_data_out <= port_a_mailbox_select ?
                         gen_word(b2a_mail_reg, port_a_parity_gen_en, parity_odd) :
                         gen_word(b2a_out_reg, port_a_parity_gen_en, parity_odd);
      port_b_data_out <= mail_b ?
                         gen_word(a2b_mail_reg, port_b_parity_gen_en, parity_odd) :
                         gen_word(a2b_out_reg, port_b_parity_gen_en, parity_odd);
      port_a_data_oe_n <= port_a_select_n | port_a_write_read;
      port_b_data_oe_n <= port_b_select_n | port_b_write_read;
      if (!ctrl_chk_en_reg)
        port_a_parity_error_n <= 1'b1;
      else if (!port_a_write_read && port_a_mailbox_select && port_a_parity_gen_en)
        port_a_parity_error_n <= 1'b1;
      else
        port_a_parity_error_n <= ~word_bad(port_a_data_in, `MASK_LONG, parity_odd);
      if (!ctrl_chk_en_reg)
        port_b_parity_error_n <= 1'b1;
      else if (!port_b_write_read && mail_b && port_b_parity_gen_en)
        port_b_parity_error_n <= 1'b1;   // trees shared with generation
      else
        port_b_parity_error_n <= ~word_bad(port_b_data_in, b_valid, parity_odd);
    end
  end

  // avalon slave: one wait cycle, then answer; writes act on the answer edge, read data loads on the wait edge
  wire bus_req = avs_read | avs_write;
  wire bus_ack = bus_req & ~avs_waitrequest;

  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      avs_waitrequest <= 1'b1;
      avs_readdata    <= 32'h00000000;
      ctrl_chk_en_reg <= `CTRL_RESET;
    end else begin
      avs_waitrequest <= ~(bus_req & avs_waitrequest);
      if (bus_ack && avs_write && avs_address == `REG_CTRL)
        ctrl_chk_en_reg <= avs_writedata[`CTRL_CHK_EN];
      if (avs_read && avs_waitrequest) begin
        avs_readdata <= 32'h00000000; // unmapped reads return zero
        if (avs_address == `REG_CTRL)
          avs_readdata[`CTRL_CHK_EN] <= ctrl_chk_en_reg;
        else if (avs_address == `REG_STATUS)
          avs_readdata[11:0] <= {a2b_level <= offset_val, b2a_level <= offset_val,
                                 (`DEPTH - a2b_level) <= offset_val, (`DEPTH - b2a_level) <= offset_val,
                                 port_b_parity_error_n, port_a_parity_error_n,
                                 b_to_a_mail_flag_n, a_to_b_mail_flag_n,
                                 port_b_full_n, port_a_full_n, port_b_empty_n, port_a_empty_n};
        else if (avs_address == `REG_LEVEL) begin
          avs_readdata[`LVL_A2B_LSB +: `PTR_W] <= a2b_level;
          avs_readdata[`LVL_B2A_LSB +: `PTR_W] <= b2a_level;
        end else if (avs_address == `REG_OFFSET)
          avs_readdata[`PTR_W-1:0] <= offset_val;
      end
    end
  end

endmodule // bidir_fifo

`default_nettype wire

/* File: bidir_fifo_defines.vh */
// Purpose: shared constants for the two-port bidirectional fifo controller
// Assumes: included by its bare name from the design file
// Notes:   definitions only
`ifndef BIDIR_FIFO_DEFINES_VH
`define BIDIR_FIFO_DEFINES_VH

// storage geometry
`define WORD_W        36
`define DEPTH         7'h40
`define ADDR_W        6
`define PTR_W         7

// parity byte layout: four nine-bit bytes, top bit is parity
`define BYTE_W        9

// port b size codes {hi,lo}
`define SIZE_LONG     2'h0
`define SIZE_WORD     2'h1
`define SIZE_BYTE     2'h2
`define SIZE_MAIL     2'h3

// byte valid masks per size, low bytes used for narrow sizes
`define MASK_LONG     4'hF
`define MASK_WORD     4'h3
`define MASK_BYTE     4'h1

// almost-full / almost-empty offset presets picked at reset
`define OFFSET_0      7'h10
`define OFFSET_1      7'h0C
`define OFFSET_2      7'h08
`define OFFSET_3      7'h04

// avalon register map (byte addresses, word index in bits 3:2)
`define REG_CTRL      4'h0
`define REG_STATUS    4'h4
`define REG_LEVEL     4'h8
`define REG_OFFSET    4'hC

// control register fields and reset value
`define CTRL_CHK_EN   0
`define CTRL_RESET    1'h1

// level register fields
`define LVL_A2B_LSB   0
`define LVL_B2A_LSB   16

`endif

/* File: bidir_fifo_assertions.sv */
// Purpose: pin timing checks for the bidirectional fifo controller
// Assumes: port clocks are sampled by sys_clk, as on the design side
// Notes:   bound to every bidir_fifo instance
`timescale 1ns/100ps
`default_nettype none
module bidir_fifo_assertions (
  // system
  input wire sys_clk,
  input wire nrst,
  // port a
  input wire port_a_clock,
  input wire port_a_select_n,
  input wire port_a_enable,
  input wire port_a_write_read,
  input wire port_a_mailbox_select,
  input wire port_a_parity_gen_en,
  input wire port_a_data_oe_n,
  input wire port_a_full_n,
  input wire port_a_parity_error_n,
  // port b
  input wire port_b_clock,
  input wire port_b_select_n,
  input wire port_b_enable,
  input wire port_b_write_read,
  input wire port_b_size_lo,
  input wire port_b_size_hi,
  input wire port_b_data_oe_n,
  input wire port_b_empty_n,
  // mailbox flags
  input wire a_to_b_mail_flag_n,
  input wire b_to_a_mail_flag_n
);
  reg  a_clk_q, b_clk_q;
  wire a_edge, b_edge, a_ev, b_ev, a_mwr, b_mwr, a_mrd, b_mrd;
  // last sampled port clocks; reset to 0 like the design's own edge history
  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      a_clk_q <= 1'b0;
      b_clk_q <= 1'b0;
    end else begin
      a_clk_q <= port_a_clock;
      b_clk_q <= port_b_clock;
    end
  end
  // selected port accesses
  assign a_edge = port_a_clock & ~a_clk_q;
  assign b_edge = port_b_clock & ~b_clk_q;
  assign a_ev   = a_edge & ~port_a_select_n & port_a_enable;
  assign b_ev   = b_edge & ~port_b_select_n & port_b_enable;
  assign a_mwr  = a_ev & port_a_write_read & port_a_mailbox_select;
  assign a_mrd  = a_ev & ~port_a_write_read & port_a_mailbox_select;
  assign b_mwr  = b_ev & port_b_write_read & port_b_size_hi & port_b_size_lo;
  assign b_mrd  = b_ev & ~port_b_write_read & port_b_size_hi & port_b_size_lo;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  // a mailbox write that finds the mailbox free
  sequence s_ab_post;
    a_mwr && a_to_b_mail_flag_n;
  endsequence
  sequence s_ba_post;
    b_mwr && b_to_a_mail_flag_n;
  endsequence
  a_b_float: assert property (port_b_select_n |=> port_b_data_oe_n) else $error("port b drives while deselected");
  a_a_wr_float: assert property (port_a_write_read |=> port_a_data_oe_n) else $error("port a drives on write");
  a_ab_lock: assert property (s_ab_post |=> !a_to_b_mail_flag_n) else $error("a-to-b flag not cleared");
  a_ab_free: assert property (b_mrd && !a_mwr |=> a_to_b_mail_flag_n) else $error("a-to-b flag not set");
  a_ab_cause: assert property ($rose(a_to_b_mail_flag_n) |-> $past(b_mrd)) else $error("a-to-b flag rose alone");
  a_ba_lock: assert property (s_ba_post |=> !b_to_a_mail_flag_n) else $error("b-to-a flag not cleared");
  a_ba_free: assert property (a_mrd && !b_mwr |=> b_to_a_mail_flag_n) else $error("b-to-a flag not set");
  a_a_full_edge: assert property ($rose(port_a_full_n) |-> $past(a_edge)) else $error("full a off edge");
  a_b_empty_edge: assert property ($rose(port_b_empty_n) |-> $past(b_edge)) else $error("empty b off edge");
  a_a_gen_quiet: assert property (!port_a_write_read && port_a_mailbox_select && port_a_parity_gen_en
    |=> port_a_parity_error_n) else $error("parity a not forced high");
endmodule // bidir_fifo_assertions
bind bidir_fifo bidir_fifo_assertions u_chk (.sys_clk, .nrst, .port_a_clock, .port_a_select_n, .port_a_enable,
  .port_a_write_read, .port_a_mailbox_select, .port_a_parity_gen_en, .port_a_data_oe_n, .port_a_full_n,
  .port_a_parity_error_n, .port_b_clock, .port_b_select_n, .port_b_enable, .port_b_write_read, .port_b_size_lo,
  .port_b_size_hi, .port_b_data_oe_n, .port_b_empty_n, .a_to_b_mail_flag_n, .b_to_a_mail_flag_n);
`default_nettype wire

/* File: port_host.sv */
// Purpose: synchronous host on one fifo port
// Assumes: port clock free-running at half the sys_clk rate
// Notes:   released data pin shows the inverse of the last value
`timescale 1ns/100ps
`default_nettype none
module port_host (
  // system
  input  wire logic        sys_clk,
  // port controls
  output var  logic        pclk,
  output var  logic        sel_n,
  output var  logic        en,
  output var  logic        wr,
  output var  logic [1:0]  mode,
  // data pin
  output wire logic [35:0] pin,
  input  wire logic [35:0] dev_out,
  input  wire logic        dev_oe_n
);
  logic [35:0] data_r;
  initial begin
    pclk = 1'b0;
    sel_n = 1'b1;
    en = 1'b0;
    wr = 1'b0;
    mode = 2'h0;
    data_r = 36'h0;
  end
  // clock keeps running through reset too
  always @(posedge sys_clk) pclk <= ~pclk;
  // wire level from both enables
  assign pin = !dev_oe_n ? dev_out : (wr ? data_r : ~data_r);
  // set levels, no access made
  task setup(input logic s, input logic e, input logic w, input logic [1:0] m, input logic [35:0] d);
    sel_n <= ~s;
    en <= e;
    wr <= w;
    mode <= m;
    data_r <= d;
  endtask
  // one access: set as the clock goes low, held through the next rising edge
  task xfer(input logic s, input logic e, input logic w, input logic [1:0] m, input logic [35:0] d);
    @(posedge sys_clk);
    while (pclk !== 1'b1) @(posedge sys_clk);
    setup(s, e, w, m, d);
    @(posedge sys_clk);
    @(posedge sys_clk);
    sel_n <= 1'b1;
    en <= 1'b0;
  endtask
endmodule // port_host
`default_nettype wire

/* File: bidir_fifo_tb_top.sv */
// Purpose: self-checking bench for the bidirectional fifo controller
// Assumes: two port_host models, avalon master in this module
// Notes:   reset spans five rising edges of each port clock
`include "bidir_fifo_defines.vh"
`timescale 1ns/100ps
`default_nettype none
module bidir_fifo_tb_top;
  logic        sys_clk, nrst, offset_select_lo, offset_select_hi, parity_odd;
  logic        port_a_parity_gen_en, port_b_parity_gen_en, avs_read, avs_write;
  logic [3:0]  avs_address;
  logic [31:0] avs_writedata, rd;
  wire  [31:0] avs_readdata;
  wire  [35:0] port_a_data_in, port_a_data_out, port_b_data_in, port_b_data_out;
  wire  [1:0]  a_mode;
  wire         port_a_clock, port_a_select_n, port_a_enable, port_a_write_read, port_a_data_oe_n;
  wire         port_b_clock, port_b_select_n, port_b_enable, port_b_write_read, port_b_data_oe_n;
  wire         port_b_size_lo, port_b_size_hi, avs_waitrequest, a_to_b_mail_flag_n, b_to_a_mail_flag_n;
  wire         port_a_empty_n, port_a_full_n, port_a_parity_error_n, port_b_empty_n, port_b_full_n;
  wire         port_b_parity_error_n;
  integer      n_errors = 0, checked = 0, i;
  bidir_fifo uut (.sys_clk, .nrst, .offset_select_lo, .offset_select_hi, .parity_odd, .port_a_clock,
    .port_a_select_n, .port_a_enable, .port_a_write_read, .port_a_mailbox_select(a_mode[0]), .port_a_parity_gen_en,
    .port_a_data_in, .port_a_data_out, .port_a_data_oe_n, .port_a_empty_n, .port_a_full_n, .port_a_parity_error_n,
    .port_b_clock, .port_b_select_n, .port_b_enable, .port_b_write_read, .port_b_size_lo, .port_b_size_hi,
    .port_b_parity_gen_en, .port_b_data_in, .port_b_data_out, .port_b_data_oe_n, .port_b_empty_n, .port_b_full_n,
    .port_b_parity_error_n, .a_to_b_mail_flag_n, .b_to_a_mail_flag_n, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_readdata, .avs_waitrequest);
  port_host ha (.sys_clk, .pclk(port_a_clock), .sel_n(port_a_select_n), .en(port_a_enable),
    .wr(port_a_write_read), .mode(a_mode), .pin(port_a_data_in), .dev_out(port_a_data_out),
    .dev_oe_n(port_a_data_oe_n));
  port_host hb (.sys_clk, .pclk(port_b_clock), .sel_n(port_b_select_n), .en(port_b_enable),
    .wr(port_b_write_read), .mode({port_b_size_hi, port_b_size_lo}), .pin(port_b_data_in),
    .dev_out(port_b_data_out), .dev_oe_n(port_b_data_oe_n));
  // 50 ns clock
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  task check(input logic [35:0] seen, input logic [35:0] exp);
    checked = checked + 1;
    if (seen !== exp) begin
      n_errors = n_errors + 1;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task stop_test;
    $display("errors %0d, checks %0d", n_errors, checked);
    if (n_errors == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // wait n edges, then one step so registered outputs have settled
  task wt(input integer n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  // avalon transfer held until waitrequest is sampled low; only the watchdog ends a hang
  task av(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= ~w;
    @(posedge sys_clk);
    while (avs_waitrequest !== 1'b0) @(posedge sys_clk);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task t_reset;
    wt(8);
    check({port_a_full_n, port_b_full_n}, 2'h3);
    offset_select_hi <= 1'b0;
    av(0, `REG_OFFSET, 32'h0);
    check(rd[6:0], `OFFSET_2);
    av(0, `REG_CTRL, 32'h0);
    check(rd[0], `CTRL_RESET);
  endtask
  task t_a2b;
    ha.xfer(1, 0, 1, 2'h0, 36'hAAAAAAAAA);
    ha.xfer(1, 1, 1, 2'h0, 36'h123456789);
    wt(8);
    check(port_b_empty_n, 1'b1);
    hb.xfer(1, 1, 0, `SIZE_LONG, 36'h0);
    wt(3);
    check(port_b_data_out, 36'h123456789);
    check(port_b_empty_n, 1'b0);
    hb.xfer(1, 1, 0, `SIZE_LONG, 36'h0);
    wt(3);
    check(port_b_data_out, 36'h123456789);
  endtask
  task t_b2a;
    hb.xfer(0, 1, 1, `SIZE_LONG, 36'h0F0F0F0F0);
    hb.xfer(1, 1, 1, `SIZE_LONG, 36'h876543210);
    wt(8);
    check(port_a_empty_n, 1'b1);
    ha.xfer(1, 1, 0, 2'h0, 36'h0);
    wt(3);
    check(port_a_data_out, 36'h876543210);
    check(port_a_empty_n, 1'b0);
  endtask
  task t_mail;
    ha.xfer(1, 1, 1, 2'h1, 36'h111111111);
    ha.xfer(1, 1, 1, 2'h1, 36'h222222222);
    wt(2);
    check(a_to_b_mail_flag_n, 1'b0);
    hb.xfer(1, 1, 0, `SIZE_MAIL, 36'h0);
    wt(3);
    check(port_b_data_out, 36'h111111111);
    check(a_to_b_mail_flag_n, 1'b1);
    hb.xfer(1, 1, 1, `SIZE_MAIL, 36'h000000001);
    wt(2);
    check(b_to_a_mail_flag_n, 1'b0);
    port_a_parity_gen_en <= 1'b1;
    ha.xfer(1, 1, 0, 2'h1, 36'h0);
    wt(3);
    check(port_a_data_out, 36'h000000101);
    check(b_to_a_mail_flag_n, 1'b1);
    check(port_a_parity_error_n, 1'b1);
    port_a_parity_gen_en <= 1'b0;
  endtask
  task t_parity;
    ha.setup(0, 0, 1, 2'h0, 36'h000000001);
    wt(3);
    check(port_a_parity_error_n, 1'b0);
    ha.setup(0, 0, 1, 2'h0, 36'h804020100);
    wt(3);
    check(port_a_parity_error_n, 1'b0);
    parity_odd <= 1'b1;
    wt(3);
    check(port_a_parity_error_n, 1'b1);
    parity_odd <= 1'b0;
    av(1, `REG_CTRL, 32'h0);
    wt(3);
    check(port_a_parity_error_n, 1'b1);
    av(1, `REG_CTRL, 32'h1);
    hb.setup(0, 0, 1, `SIZE_BYTE, 36'h800000000);
    wt(3);
    check(port_b_parity_error_n, 1'b1);
    hb.setup(0, 0, 1, `SIZE_LONG, 36'h800000000);
    wt(3);
    check(port_b_parity_error_n, 1'b0);
    hb.setup(0, 0, 1, `SIZE_WORD, 36'h000000200);
    wt(3);
    check(port_b_parity_error_n, 1'b0);
    ha.setup(0, 0, 1, 2'h0, 36'h0);
    hb.setup(0, 0, 1, `SIZE_LONG, 36'h0);
  endtask
  task t_full;
    for (i = 0; i < 64; i = i + 1) ha.xfer(1, 1, 1, 2'h0, 36'(i));
    wt(2);
    check(port_a_full_n, 1'b0);
    ha.xfer(1, 1, 1, 2'h0, 36'hFFFFFFFFF);
    av(0, `REG_LEVEL, 32'h0);
    check(rd[6:0], 7'h40);
    hb.xfer(1, 1, 0, `SIZE_LONG, 36'h0);
    wt(8);
    check(port_b_data_out, 36'h0);
    check(port_a_full_n, 1'b1);
  endtask
  // hang guard, far beyond the expected run length
  initial begin
    repeat (6000) @(posedge sys_clk);
    n_errors = n_errors + 1;
    stop_test;
  end
  initial begin
    nrst = 1'b0;
    offset_select_lo = 1'b0;
    offset_select_hi = 1'b1;
    parity_odd = 1'b0;
    port_a_parity_gen_en = 1'b0;
    port_b_parity_gen_en = 1'b0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 4'h0;
    avs_writedata = 32'h0;
    // long enough for five rising edges of each port clock
    wt(10);
    check({port_a_empty_n, port_b_empty_n, port_a_full_n, port_b_full_n, a_to_b_mail_flag_n, b_to_a_mail_flag_n},
      6'h03);
    nrst = 1'b1;
    t_reset;
    t_a2b;
    t_b2a;
    t_mail;
    t_parity;
    t_full;
    stop_test;
  end
endmodule // bidir_fifo_tb_top
`default_nettype wire
